// [design/edhbr_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "edhbr_defs.svh"

module edhbr_top
    import edhbr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [`EDHBR_BUS_AW-1:0]  avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [`EDHBR_NCH-1:0]     dma_request_n,
    output logic      [`EDHBR_NCH-1:0]     dma_grant_n,
    output logic                           dma_grant_oe,
    output logic      [`EDHBR_AW-1:0]      location_bus,
    output logic                           location_bus_oe,
    input  wire logic [`EDHBR_DW-1:0]      data_in,
    output logic      [`EDHBR_DW-1:0]      data_out,
    output logic                           data_oe,
    output logic                           read_strobe_n,
    output logic                           write_strobe_n,
    output logic                           page_n,
    output logic      [3:0]                memory_select_n,
    output logic                           sync_write_select,
    output logic                           boot_memory_select_n,
    output logic                           strobe_oe,
    input  wire logic                      ack,
    input  wire logic                      bus_owned,
    input  wire logic                      suspend_bus_three_state_n,
    input  wire logic                      host_bus_request_n,
    output logic                           host_bus_grant_n
);

    edhbr_state_type s_q;
    edhbr_state_type s_d;

    logic [`EDHBR_NCH-1:0] chEnable;
    logic [`EDHBR_NCH-1:0] chDirIn;
    logic [`EDHBR_NCH-1:0] chReady;
    edhbr_mode_type        chMode [`EDHBR_NCH];

    genvar gi;
    generate
        for (gi = 0; gi < `EDHBR_NCH; gi++)
        begin : gen_ch
            assign chEnable[gi] = s_q.ctrl[`EDHBR_CTRL_EN_LSB + gi];
            assign chDirIn[gi]  = s_q.ctrl[`EDHBR_CTRL_DIR_LSB + gi];
            assign chMode[gi]   = edhbr_mode_type'(s_q.ctrl[`EDHBR_CTRL_MODE_LSB + 2*gi +: 2]);
            // A channel is only started while its data has somewhere to go, so a stalled reader backs
            // the peripheral up instead of losing words.
            assign chReady[gi]  = chEnable[gi] && (chMode[gi] != MODE_OFF) && s_q.armed[gi]
                                  && s_q.reqLow[gi]
                                  && (chDirIn[gi] ? (s_q.fifoCnt != 2'(`EDHBR_FIFO_DEPTH)) : s_q.txValid);
        end
    endgenerate

    logic        busWrOk;
    logic        busRdOk;
    logic        txBlock;
    logic        pushRx;
    logic        popRx;
    logic        popTx;
    logic        accessDone;
    logic        active;
    logic        pick;
    logic [31:0] statusWord;

    assign txBlock         = avs_write && (avs_address == `EDHBR_OFF_TXDATA) && s_q.txValid;
    assign avs_waitrequest = avs_read ? !s_q.rdPending : txBlock;
    assign avs_readdata    = s_q.readdata;

    always_comb
    begin
        s_d        = s_q;
        busWrOk    = avs_write && !txBlock;
        busRdOk    = avs_read && s_q.rdPending;
        pushRx     = 1'b0;
        popTx      = 1'b0;
        popRx      = 1'b0;
        accessDone = 1'b0;
        pick       = 1'b0;
        statusWord = {13'h0000, s_q.fifoCnt, s_q.txValid, s_q.host == HOST_GRANT, s_q.memEn,
                      s_q.ch, s_q.eng != ST_IDLE, s_q.doneCnt[11:0]};

        s_d.reqLow = ~dma_request_n;
        for (int i = 0; i < `EDHBR_NCH; i++)
        begin
            if (!s_q.reqLow[i])
            begin
                s_d.armed[i] = 1'b1;
            end
        end

        // Bus mastership, host hand-over and suspend all pull the drivers off together.
        s_d.memEn = bus_owned && suspend_bus_three_state_n && (s_q.host == HOST_NONE);

        case (s_q.host)
            HOST_NONE:
            begin
                if (!host_bus_request_n && (s_q.eng == ST_IDLE))
                begin
                    s_d.host  = HOST_FLOAT;
                    s_d.memEn = 1'b0;
                end
            end
            HOST_FLOAT:
            begin
                if (!s_q.memEn)
                begin
                    s_d.host = HOST_GRANT;
                end
            end
            HOST_GRANT:
            begin
                if (host_bus_request_n)
                begin
                    s_d.host = HOST_RELEASE;
                end
            end
            HOST_RELEASE:
            begin
                s_d.host = HOST_NONE;
            end
            default:
            begin
                s_d.host = HOST_NONE;
            end
        endcase

        // A suspended or floated interface freezes the engine where it stands.
        if (s_q.memEn)
        begin
            case (s_q.eng)
                ST_IDLE:
                begin
                    for (int i = `EDHBR_NCH - 1; i >= 0; i--)
                    begin
                        if (chReady[i] && (s_q.host == HOST_NONE) && !(!host_bus_request_n))
                        begin
                            pick      = 1'b1;
                            s_d.ch    = 1'(i);
                            s_d.mode  = chMode[i];
                            s_d.dirIn = chDirIn[i];
                        end
                    end
                    if (pick)
                    begin
                        s_d.armed[s_d.ch] = 1'b0;
                        s_d.waitCnt       = s_q.waitCfg[`EDHBR_WAIT_WS_LSB +: 3];
                        if (s_q.idlePending && s_q.waitCfg[`EDHBR_WAIT_IDLE_BIT])
                        begin
                            s_d.eng = ST_GAP;
                        end
                        else
                        begin
                            s_d.eng = ST_ACCESS;
                        end
                    end
                    s_d.idlePending = 1'b0;
                end
                ST_GAP:
                begin
                    s_d.eng = ST_ACCESS;
                end
                ST_ACCESS:
                begin
                    if (s_q.waitCnt != 3'h0)
                    begin
                        s_d.waitCnt = 3'(s_q.waitCnt - 3'h1);
                    end
                    else if ((s_q.mode != MODE_HANDSHAKE) && !ack)
                    begin
                        s_d.eng = ST_ACCESS;
                    end
                    else if (s_q.reqLow[s_q.ch])
                    begin
                        s_d.eng = ST_ACCESS;
                    end
                    else
                    begin
                        accessDone      = 1'b1;
                        s_d.eng         = ST_IDLE;
                        s_d.idlePending = 1'b1;
                        s_d.doneCnt     = 16'(s_q.doneCnt + 16'h0001);
                        if (s_q.dirIn)
                        begin
                            pushRx = 1'b1;
                        end
                        else
                        begin
                            popTx = 1'b1;
                        end
                    end
                end
                default:
                begin
                    s_d.eng = ST_IDLE;
                end
            endcase
        end

        if (avs_read && !s_q.rdPending)
        begin
            case (avs_address)
                `EDHBR_OFF_CTRL:   s_d.readdata = s_q.ctrl;
                `EDHBR_OFF_WAIT:   s_d.readdata = {28'h000_0000, s_q.waitCfg};
                `EDHBR_OFF_STATUS: s_d.readdata = statusWord;
                `EDHBR_OFF_TXDATA: s_d.readdata = s_q.tx;
                `EDHBR_OFF_RXDATA: s_d.readdata = (s_q.fifoCnt != 2'h0) ? s_q.fifo[s_q.fifoRd] : 32'h0000_0000;
                `EDHBR_OFF_ADDR:   s_d.readdata = s_q.addr;
                `EDHBR_OFF_COUNT:  s_d.readdata = {16'h0000, s_q.doneCnt};
                default:           s_d.readdata = 32'h0000_0000;
            endcase
        end
        s_d.rdPending = avs_read && !s_q.rdPending;
        popRx = busRdOk && (avs_address == `EDHBR_OFF_RXDATA) && (s_q.fifoCnt != 2'h0);

        if (busWrOk)
        begin
            case (avs_address)
                `EDHBR_OFF_CTRL:   s_d.ctrl    = avs_writedata & `EDHBR_CTRL_MASK;
                `EDHBR_OFF_WAIT:   s_d.waitCfg = avs_writedata[3:0];
                `EDHBR_OFF_ADDR:   s_d.addr    = avs_writedata;
                `EDHBR_OFF_TXDATA: s_d.tx      = avs_writedata;
                `EDHBR_OFF_COUNT:  s_d.doneCnt = {15'h0000, accessDone};
                default:           s_d.ctrl    = s_q.ctrl;
            endcase
        end

        if (busWrOk && (avs_address == `EDHBR_OFF_TXDATA))
        begin
            s_d.txValid = 1'b1;
        end
        else if (popTx)
        begin
            s_d.txValid = 1'b0;
        end

        if (pushRx)
        begin
            s_d.fifo[s_q.fifoWr] = data_in;
            s_d.fifoWr           = !s_q.fifoWr;
        end
        if (popRx)
        begin
            s_d.fifoRd = !s_q.fifoRd;
        end
        s_d.fifoCnt = 2'(s_q.fifoCnt + {1'b0, pushRx} - {1'b0, popRx});

        active                  = (s_d.eng == ST_ACCESS);
        s_d.pins.ctlOe          = s_d.memEn;
        s_d.pins.dataOe         = s_d.memEn && active && !s_d.dirIn;
        s_d.pins.dataOut        = s_d.tx;
        s_d.pins.rdN            = !(active && s_d.dirIn);
        s_d.pins.wrN            = !(active && !s_d.dirIn);
        s_d.pins.syncWriteSel   = active && !s_d.dirIn;
        s_d.pins.bootSelN       = 1'b1;
        s_d.pins.location       = (active && (s_d.mode != MODE_HANDSHAKE)) ? s_d.addr : 32'h0000_0000;
        s_d.pins.memSelN        = (active && (s_d.mode != MODE_HANDSHAKE))
                                  ? ~s_d.ctrl[`EDHBR_CTRL_SEL_LSB +: 4] : 4'hF;
        s_d.pins.pageN          = !(active && (s_d.mode == MODE_EXTERNAL) && s_d.ctrl[`EDHBR_CTRL_PAGE_BIT]);
        for (int i = 0; i < `EDHBR_NCH; i++)
        begin
            s_d.pins.grantN[i] = !(active && (s_d.ch == 1'(i)) && (s_d.mode != MODE_PACED));
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q                   <= '0;
            s_q.eng               <= ST_IDLE;
            s_q.host              <= HOST_NONE;
            s_q.ctrl              <= `EDHBR_CTRL_RESET;
            s_q.waitCfg           <= `EDHBR_WAIT_RESET;
            s_q.addr              <= `EDHBR_ADDR_RESET;
            s_q.pins.rdN          <= 1'b1;
            s_q.pins.wrN          <= 1'b1;
            s_q.pins.pageN        <= 1'b1;
            s_q.pins.memSelN      <= 4'hF;
            s_q.pins.bootSelN     <= 1'b1;
            s_q.pins.grantN       <= '1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign dma_grant_n          = s_q.pins.grantN;
    assign dma_grant_oe         = s_q.pins.ctlOe;
    assign location_bus         = s_q.pins.location;
    assign location_bus_oe      = s_q.pins.ctlOe;
    assign data_out             = s_q.pins.dataOut;
    assign data_oe              = s_q.pins.dataOe;
    assign read_strobe_n        = s_q.pins.rdN;
    assign write_strobe_n       = s_q.pins.wrN;
    assign page_n               = s_q.pins.pageN;
    assign memory_select_n      = s_q.pins.memSelN;
    assign sync_write_select    = s_q.pins.syncWriteSel;
    assign boot_memory_select_n = s_q.pins.bootSelN;
    assign strobe_oe            = s_q.pins.ctlOe;
    // The grant pin itself is never floated, so the host always sees a defined level.
    assign host_bus_grant_n     = !(s_q.host == HOST_GRANT);

endmodule : edhbr_top

`default_nettype wire

// [pkg/edhbr_defs.svh]
`ifndef EDHBR_DEFS_SVH
`define EDHBR_DEFS_SVH

`define EDHBR_NCH             2
`define EDHBR_AW              32
`define EDHBR_DW              32
`define EDHBR_BUS_AW          6

`define EDHBR_OFF_CTRL        6'h00
`define EDHBR_OFF_WAIT        6'h04
`define EDHBR_OFF_STATUS      6'h08
`define EDHBR_OFF_TXDATA      6'h0C
`define EDHBR_OFF_RXDATA      6'h10
`define EDHBR_OFF_ADDR        6'h14
`define EDHBR_OFF_COUNT       6'h18

`define EDHBR_CTRL_EN_LSB     0
`define EDHBR_CTRL_MODE_LSB   2
`define EDHBR_CTRL_DIR_LSB    6
`define EDHBR_CTRL_SEL_LSB    8
`define EDHBR_CTRL_PAGE_BIT   12
`define EDHBR_CTRL_MASK       32'h0000_1FFF
`define EDHBR_CTRL_RESET      32'h0000_0000

`define EDHBR_WAIT_WS_LSB     0
`define EDHBR_WAIT_IDLE_BIT   3
`define EDHBR_WAIT_RESET      4'h0

`define EDHBR_ADDR_RESET      32'h0000_0000
`define EDHBR_FIFO_DEPTH      2

`endif

// [pkg/edhbr_pkg.sv]
`default_nettype none
`include "edhbr_defs.svh"

package edhbr_pkg;

    typedef enum logic [1:0] {
        MODE_HANDSHAKE,
        MODE_EXTERNAL,
        MODE_PACED,
        MODE_OFF
    } edhbr_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_GAP,
        ST_ACCESS
    } edhbr_eng_type;

    typedef enum logic [1:0] {
        HOST_NONE,
        HOST_FLOAT,
        HOST_GRANT,
        HOST_RELEASE
    } edhbr_host_type;

    typedef struct packed {
        logic [`EDHBR_AW-1:0] location;
        logic [`EDHBR_DW-1:0] dataOut;
        logic                 dataOe;
        logic                 rdN;
        logic                 wrN;
        logic                 pageN;
        logic [3:0]           memSelN;
        logic                 syncWriteSel;
        logic                 bootSelN;
        logic                 ctlOe;
        logic [`EDHBR_NCH-1:0] grantN;
    } edhbr_pins_type;

    typedef struct packed {
        edhbr_eng_type        eng;
        edhbr_host_type       host;
        logic                 memEn;
        logic                 ch;
        edhbr_mode_type       mode;
        logic                 dirIn;
        logic [2:0]           waitCnt;
        logic                 idlePending;
        logic [31:0]          ctrl;
        logic [3:0]           waitCfg;
        logic [31:0]          addr;
        logic [31:0]          tx;
        logic                 txValid;
        logic [`EDHBR_FIFO_DEPTH-1:0][31:0] fifo;
        logic                 fifoWr;
        logic                 fifoRd;
        logic [1:0]           fifoCnt;
        logic [`EDHBR_NCH-1:0] armed;
        logic [`EDHBR_NCH-1:0] reqLow;
        logic                 rdPending;
        logic [31:0]          readdata;
        logic [15:0]          doneCnt;
        edhbr_pins_type       pins;
    } edhbr_state_type;

endpackage : edhbr_pkg

`default_nettype wire

// [test/edhbr_periph.sv]
`timescale 1ns/1ps
`default_nettype none
module edhbr_periph (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic [3:0]  hold,
    input  wire logic [3:0]  ackDly,
    input  wire logic [31:0] word,
    input  wire logic        dmaGrantN,
    input  wire logic        rdN,
    input  wire logic        wrN,
    output logic             reqN = 1'b1,
    output logic             ack = 1'b0,
    output logic [31:0]      dataIn = 32'h0000_0000
);
    logic       seen;
    logic       seenQ;
    logic [1:0] st;
    logic [1:0] pend;
    logic [1:0] keep;
    logic [3:0] cnt;
    logic [3:0] ackCnt;
    assign seen = !dmaGrantN || !rdN || !wrN;
    // Data is offered only after the request rises and toggles otherwise, so a device that latches early fails.
    always @(posedge clk)
    begin
        seenQ <= seen;
        ackCnt <= seen ? ackCnt + {3'h0, ackCnt != 4'hF} : 4'h0;
        ack <= seen && ackCnt >= ackDly;
        dataIn <= keep != 2'h0 ? word : ~dataIn;
        keep <= keep - {1'b0, keep != 2'h0};
        pend <= pend + {1'b0, go} - {1'b0, st == 2'h0 && pend != 2'h0};
        if (!rst_n)
        begin
            st <= 2'h0;
            reqN <= 1'b1;
            pend <= 2'h0;
            keep <= 2'h0;
        end
        else if (st == 2'h0 && pend != 2'h0)
        begin
            reqN <= 1'b0;
            st <= 2'h1;
        end
        else if (st == 2'h1 && seen && !seenQ)
        begin
            cnt <= 4'h0;
            st <= 2'h2;
        end
        else if (st == 2'h2 && cnt != hold)
            cnt <= cnt + 4'h1;
        else if (st == 2'h2)
        begin
            reqN <= 1'b1;
            keep <= 2'h3;
            st <= 2'h0;
        end
    end
endmodule : edhbr_periph
`default_nettype wire

// [test/edhbr_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "edhbr_defs.svh"
module edhbr_top_sva (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [`EDHBR_BUS_AW-1:0] avs_address,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_writedata,
    input wire logic                  avs_waitrequest,
    input wire logic [`EDHBR_NCH-1:0] dma_request_n,
    input wire logic [`EDHBR_NCH-1:0] dma_grant_n,
    input wire logic                  dma_grant_oe,
    input wire logic                  location_bus_oe,
    input wire logic                  data_oe,
    input wire logic                  read_strobe_n,
    input wire logic                  write_strobe_n,
    input wire logic                  strobe_oe,
    input wire logic                  bus_owned,
    input wire logic                  suspend_bus_three_state_n,
    input wire logic                  host_bus_grant_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // The idle-cycle option is only visible on the register bus, so its last accepted write is tracked here.
    logic idleEn;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            idleEn <= 1'b0;
        else if (avs_write && !avs_waitrequest && (avs_address == `EDHBR_OFF_WAIT))
            idleEn <= avs_writedata[`EDHBR_WAIT_IDLE_BIT];
    end
    AST_FLOAT_BEFORE_HOST: assert property (
        $fell(host_bus_grant_n) |-> !$past(strobe_oe) && !$past(location_bus_oe) && !$past(dma_grant_oe))
        else $error("interface still driven when host grant fell");
    AST_FLOAT_WHILE_HOST: assert property (
        !host_bus_grant_n |-> !strobe_oe && !location_bus_oe && !data_oe && !dma_grant_oe)
        else $error("interface driven during host grant");
    AST_DRIVE_AFTER_HOST: assert property (
        $rose(host_bus_grant_n) |-> !strobe_oe ##1 !strobe_oe
            ##1 (strobe_oe || !$past(bus_owned) || !$past(suspend_bus_three_state_n)))
        else $error("interface resume order after host grant wrong");
    AST_SUSPEND_FLOATS: assert property (
        !suspend_bus_three_state_n |=> !strobe_oe && !location_bus_oe && !data_oe && !dma_grant_oe)
        else $error("interface driven during suspend");
    AST_OWNER_LOSS: assert property (
        !bus_owned |=> !strobe_oe && !location_bus_oe)
        else $error("interface driven without bus ownership");
    AST_RESUME: assert property (
        $rose(suspend_bus_three_state_n) && bus_owned && host_bus_grant_n |-> ##[1:2] strobe_oe)
        else $error("interface not driven again after suspend");
    AST_GRANT_AFTER_REQ: assert property (
        $fell(dma_grant_n[0]) |-> !$past(dma_request_n[0], 2) && !$past(dma_request_n[0]))
        else $error("grant without a sampled request");
    AST_GRANT_HOLDS: assert property (
        !dma_grant_n[0] && !dma_request_n[0] && !$past(dma_request_n[0]) |-> ##2 !dma_grant_n[0])
        else $error("grant ended while request held low");
    AST_ACCESS_HAS_STROBE: assert property (
        $fell(dma_grant_n[0]) |-> (!read_strobe_n || !write_strobe_n) && dma_grant_oe)
        else $error("grant without strobe");
    AST_GRANT_GAP: assert property (
        $rose(dma_grant_n[0]) && idleEn |=> dma_grant_n[0])
        else $error("grant low again without gap");
    AST_DATA_WITH_WRITE: assert property (
        $rose(data_oe) |-> !write_strobe_n && strobe_oe)
        else $error("data enabled off the write strobe edge");
    AST_DATA_DROPS: assert property (
        $rose(write_strobe_n) |-> !data_oe)
        else $error("data still driven after write strobe");
endmodule : edhbr_top_sva
bind edhbr_top edhbr_top_sva u_sva (.clk, .rst_n, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
    .dma_request_n, .dma_grant_n, .dma_grant_oe, .location_bus_oe,
    .data_oe, .read_strobe_n, .write_strobe_n, .strobe_oe, .bus_owned, .suspend_bus_three_state_n, .host_bus_grant_n);
`default_nettype wire

// [test/edhbr_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "edhbr_defs.svh"
module edhbr_top_bench import edhbr_pkg::*;;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic        hbrN = 1'b1;
    logic        own = 1'b1;
    logic        suspN = 1'b1;
    logic        go = 1'b0;
    logic        chSel = 1'b0;
    logic [3:0]  hold = 4'h0;
    logic [3:0]  ackD = 4'h0;
    logic [31:0] word = 32'h0000_0000;
    logic        reqN, ack, acc, sawGrant, wreq, rdN, wrN, soe, loe, hbgN, pgN, pgSeen, sws, bmsN;
    logic [1:0]  grantN;
    logic [3:0]  msN, selSeen;
    logic [31:0] rdat, dIn, dOut, locBus, locSeen;
    logic [31:0] expQ[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          run = 0, gap = 0, lastLen = 0, lastGap = 0, ends = 0;
    always #2 clk = ~clk;
    edhbr_top u_dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .dma_request_n(chSel ? {reqN, 1'b1} : {1'b1, reqN}), .dma_grant_n(grantN), .dma_grant_oe(),
        .location_bus(locBus), .location_bus_oe(loe), .data_in(dIn), .data_out(dOut), .data_oe(),
        .read_strobe_n(rdN), .write_strobe_n(wrN), .page_n(pgN), .memory_select_n(msN), .sync_write_select(sws),
        .boot_memory_select_n(bmsN), .strobe_oe(soe), .ack(ack), .bus_owned(own),
        .suspend_bus_three_state_n(suspN), .host_bus_request_n(hbrN), .host_bus_grant_n(hbgN));
    edhbr_periph u_far (.clk(clk), .rst_n(rst_n), .go(go), .hold(hold), .ackDly(ackD), .word(word),
        .dmaGrantN(grantN[chSel]), .rdN(rdN), .wrN(wrN), .reqN(reqN), .ack(ack), .dataIn(dIn));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // Reads push their expected word; the monitor below pops it when the answer stands.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        if (!w)
            expQ.push_back(d);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wreq !== 1'b0 && k < 500);
        if (k >= 500)
            check(32'h0000_0000, 32'h0000_0001);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic xfer(input int c, input logic [1:0] m, input logic di, input logic [3:0] wc, input logic [3:0] h,
                        input logic [3:0] ad, input logic [31:0] w, input int n);
        int e;
        int k;
        chSel <= c[0];
        hold <= h;
        ackD <= ad;
        word <= w;
        bus(1, `EDHBR_OFF_WAIT, {28'h000_0000, wc});
        bus(1, `EDHBR_OFF_CTRL, 32'h0000_0500 | (32'h1 << c) | ({30'h0, m} << (2 + 2 * c)) | (32'h3 << (4 - 2 * c))
            | ({31'h0, di} << (6 + c)) | (m == 2'h1 ? 32'h0000_1000 : 32'h0000_0000));
        if (!di)
            bus(1, `EDHBR_OFF_TXDATA, w);
        sawGrant = 1'b0;
        e = ends;
        go <= 1'b1;
        repeat (n) @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 300 && ends < e + n; k++)
            @(posedge clk);
        check(ends, e + n);
    endtask : xfer
    always @(negedge clk)
    begin
        acc = !rdN || !wrN || !grantN[chSel];
        if (acc)
        begin
            if (run == 0)
                lastGap = gap;
            run++;
            sawGrant = sawGrant | !grantN[chSel];
            locSeen = locBus;
            selSeen = msN;
            pgSeen = pgN;
            check({sws, bmsN}, {!wrN, 1'b1});
            if (!wrN)
                check(dOut, word);
        end
        else if (run != 0)
        begin
            lastLen = run;
            run = 0;
            gap = 0;
            ends++;
        end
        else
            gap++;
        if (rd && !wreq)
            check(rdat, expQ.pop_front());
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        check(32'h0000_0000, 32'h0000_0001);
        tally_and_finish;
    end
    initial
    begin
        logic [31:0] v;
        int l0;
        v = $urandom(32'h0699);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, `EDHBR_OFF_CTRL, `EDHBR_CTRL_RESET);
        bus(0, `EDHBR_OFF_WAIT, 32'h0000_0000);
        bus(0, 6'h3C, 32'h0000_0000);
        v = $urandom;
        bus(1, `EDHBR_OFF_ADDR, v);
        bus(0, `EDHBR_OFF_ADDR, v);
        for (int m = 0; m < 3; m++)
            for (int d = 0; d < 2; d++)
            begin
                xfer(m % 2, m[1:0], d[0], 4'h0, 4'h1, 4'h2, $urandom, 1);
                check(sawGrant, m != 2);
                check(locSeen, m != 0 ? v : 32'h0000_0000);
                check(selSeen, m != 0 ? 4'hA : 4'hF);
                check(pgSeen, m != 1);
                if (d != 0)
                    bus(0, `EDHBR_OFF_RXDATA, word);
            end
        xfer(0, 2'h0, 1'b0, 4'h6, 4'h0, 4'h0, $urandom, 1);
        l0 = lastLen;
        xfer(0, 2'h0, 1'b0, 4'h7, 4'h0, 4'h0, $urandom, 1);
        check(lastLen - l0, 1);
        xfer(0, 2'h0, 1'b1, 4'h0, 4'h5, 4'h0, $urandom, 1);
        l0 = lastLen;
        bus(0, `EDHBR_OFF_RXDATA, word);
        xfer(0, 2'h0, 1'b1, 4'h0, 4'h6, 4'h0, $urandom, 1);
        check(lastLen - l0, 1);
        bus(0, `EDHBR_OFF_RXDATA, word);
        xfer(0, 2'h2, 1'b0, 4'h0, 4'h0, 4'h8, $urandom, 1);
        check(lastLen >= 8, 1);
        for (int i = 0; i < 2; i++)
        begin
            xfer(0, 2'h0, 1'b1, {i[0], 3'h0}, 4'h0, 4'h0, $urandom, 2);
            if (i == 0)
                l0 = lastGap;
            else
                check(lastGap - l0, 1);
            repeat (2) bus(0, `EDHBR_OFF_RXDATA, word);
        end
        // Fill the two-entry receive buffer, then ask again: the third request must wait for room.
        xfer(0, 2'h0, 1'b1, 4'h0, 4'h2, 4'h0, $urandom, 2);
        l0 = ends;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        check(ends, l0);
        repeat (2) bus(0, `EDHBR_OFF_RXDATA, word);
        repeat (20) @(posedge clk);
        bus(0, `EDHBR_OFF_RXDATA, word);
        bus(0, `EDHBR_OFF_RXDATA, 32'h0000_0000);
        hbrN <= 1'b0;
        for (int k = 0; k < 20 && hbgN !== 1'b0; k++)
            @(posedge clk);
        check(hbgN, 1'b0);
        check(soe, 1'b0);
        check(loe, 1'b0);
        hbrN <= 1'b1;
        repeat (4) @(posedge clk);
        check(soe, 1'b1);
        for (int i = 0; i < 2; i++)
        begin
            suspN <= i[0];
            own <= !i[0];
            repeat (2) @(posedge clk);
            check(soe, 1'b0);
            check(loe, 1'b0);
            suspN <= 1'b1;
            own <= 1'b1;
            repeat (3) @(posedge clk);
            check(soe, 1'b1);
        end
        tally_and_finish;
    end
endmodule : edhbr_top_bench
`default_nettype wire
